/* hw/iro_defines.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef IRO_DEFINES_SVH
`define IRO_DEFINES_SVH
// Byte offsets of the word-wide register slots inside the block.
`define IRO_OFF_RELAY     8'h00
`define IRO_OFF_INPUT     8'h04
`define IRO_OFF_FILT      8'h08
`define IRO_OFF_SWITCH    8'h0c
`define IRO_OFF_IRQ_CTRL  8'h10
`define IRO_OFF_IRQ_STAT  8'h14
`define IRO_OFF_IRQ_CLR   8'h18
`define IRO_OFF_DEV_ID    8'h1c
// Size of the decoded block: sixteen slots of one word each.
`define IRO_BLOCK_BYTES   8'h40
// Field positions.
`define IRO_FILT_EN_BIT   0
`define IRO_IRQ_EN_BIT    0
`define IRO_IRQ_PEND_BIT  0
`define IRO_IRQ_CHG_LSB   8
// Reset values.
`define IRO_RELAY_RST     8'h00
`define IRO_FILT_EN_RST   1'b0
`define IRO_IRQ_EN_RST    1'b0
`define IRO_CHG_RST       8'h00
// Filter time constant in milliseconds and the clock rate in kHz.
`define IRO_FILT_TIME_MS  5
`define IRO_CLK_KHZ       250000
`define IRO_FILT_CYCLES   (`IRO_FILT_TIME_MS * `IRO_CLK_KHZ)
// Width of a filter counter; it must hold the cycle count above.
`define IRO_CNT_W         21
`endif

/* hw/iro_pkg.sv */
// Types shared by the isolated input and relay output block.
`include "iro_defines.svh"
package iro_pkg;
   typedef logic [7:0]            iro_chan_t;  // One bit per channel.
   typedef logic [`IRO_CNT_W-1:0] iro_cnt_t;   // Filter counter.
   // Bus slave phases.
   typedef enum logic {IRO_BUS_IDLE, IRO_BUS_ACCESS} iro_bus_t;
   // State of a two-stage synchroniser.
   typedef struct packed {
      iro_chan_t s1;
      iro_chan_t s2;
   } iro_sync_st_t;
   // State of the filter bank.
   typedef struct packed {
      iro_cnt_t [7:0] cnt;
      iro_chan_t      lvl;
   } iro_filt_st_t;
   // State of the register block.
   typedef struct packed {
      iro_bus_t    bus;
      iro_chan_t   relay;
      logic        filt_en;
      logic        irq_en;
      iro_chan_t   prev;
      iro_chan_t   chg;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        int_n;
   } iro_top_st_t;
endpackage : iro_pkg

/* hw/iro_filt_if.sv */
`timescale 1ns/1ps
// Carrier between the register block and the input filter bank.
interface iro_filt_if;
   import iro_pkg::*;
   iro_chan_t raw;  // Synchronised input levels.
   iro_chan_t en;   // Per-channel filter enables.
   iro_chan_t lvl;  // Filtered levels.
   modport ctl (output raw, output en, input lvl);
   modport flt (input raw, input en, output lvl);
endinterface : iro_filt_if

/* hw/iro_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for eight asynchronous pin levels.
module iro_sync import iro_pkg::*; (
   input  wire logic      clk,
   input  wire logic      nrst,
   input  wire iro_chan_t d,
   output iro_chan_t      q
);
   iro_sync_st_t st_q;  // Registered state.
   iro_sync_st_t st_d;  // Next state.

   // The first stage feeds only the second stage.
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   // Both stages clear under reset.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule : iro_sync

/* hw/iro_filter.sv */
`timescale 1ns/1ps
// Bank of eight integrating input filters.
module iro_filter import iro_pkg::*; #(
   parameter iro_cnt_t FILT_CYCLES = iro_cnt_t'(`IRO_FILT_CYCLES)
) (
   input  wire logic clk,
   input  wire logic nrst,
   iro_filt_if.flt   f
);
   iro_filt_st_t st_q;  // Registered state.
   iro_filt_st_t st_d;  // Next state.

   // An enabled channel changes only after its input has differed for the full
   // time constant, so short AC gaps never reach the output.
   always_comb begin
      st_d = st_q;
      for (int i = 0; i < 8; i++) begin
         if (!f.en[i]) begin
            // Unfiltered: follow the input directly.
            st_d.lvl[i] = f.raw[i];
            st_d.cnt[i] = '0;
         end else if (f.raw[i] == st_q.lvl[i]) begin
            // Agreement restarts the count.
            st_d.cnt[i] = '0;
         end else if (st_q.cnt[i] == FILT_CYCLES - iro_cnt_t'(1)) begin
            // Disagreement has lasted the time constant.
            st_d.lvl[i] = f.raw[i];
            st_d.cnt[i] = '0;
         end else begin
            st_d.cnt[i] = st_q.cnt[i] + iro_cnt_t'(1);
         end
      end
   end

   // All counters and levels clear under reset.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign f.lvl = st_q.lvl;
endmodule : iro_filter

/* hw/iro_top.sv */
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Isolated input and relay output block with its APB register file.
//
// Summary of operation
// - Decode sixteen word slots from bus base.
// - Five millisecond filter ahead of input register.
// - Filtered AC input reads as steady level.
// - Reset turns software filter enable off.
// - One write switches all eight filters; clearing it leaves channels with a switch bit set filtered.
// - Software reads back the filter enable.
// - Switch bits enable filters per channel.
// - Any input change raises enabled interrupt.
// - AC signal loss counts as change.
// - Interrupt disabled after power-on.
// - Enable, disable, clear, read interrupt status.
// - Interrupt reaches host only while enabled.
// - Reset turns all relays off.
// - Relays hold written latched bits.
// - Software reads back relay states.
// - Fixed layout; only identifier differs.
//
// All registers but the interrupt status, whose change bits sit at 15:8,
// are one byte of data in the low bits of an aligned word; the upper bits read as zero. Accesses outside the block or off
// word alignment answer with pslverr and change nothing.
`include "iro_defines.svh"
module iro_top import iro_pkg::*; #(
   // Filter time constant in clock cycles; shorten it for simulation.
   parameter iro_cnt_t  FILT_CYCLES = iro_cnt_t'(`IRO_FILT_CYCLES),
   // Device identifier; the value is arbitrary.
   parameter iro_chan_t DEV_ID      = 8'h5a
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire iro_chan_t   iso_in,
   input  wire iro_chan_t   filt_sw,
   output iro_chan_t        relay_on,
   output logic             int_a_n
);

   // Input levels after two flip-flops.
   iro_chan_t   iso_sync;
   // Switch settings after two flip-flops.
   iro_chan_t   sw_sync;
   // Registered state of the register block.
   iro_top_st_t st_q;
   // Next state of the register block.
   iro_top_st_t st_d;
   // Address lies inside the block on a word boundary.
   logic        addr_ok;
   // A setup cycle is on the bus.
   logic        setup;
   // The access phase completes at this edge.
   logic        done;
   // A write takes effect at this edge.
   logic        wr;
   // Data byte of the write.
   iro_chan_t   wbyte;
   // Channels whose filtered level changed at this edge.
   iro_chan_t   edges;
   // Pending changes that software clears at this edge.
   iro_chan_t   clr;
   // Read value chosen by the address.
   logic [31:0] rd_val;

   // Carrier to the filter bank.
   iro_filt_if fif ();

   // The input pins cross into the clock domain first.
   iro_sync u_sync_in (
      .clk  (clk),
      .nrst (nrst),
      .d    (iso_in),
      .q    (iso_sync)
   );

   // The switch settings cross into the clock domain as well.
   iro_sync u_sync_sw (
      .clk  (clk),
      .nrst (nrst),
      .d    (filt_sw),
      .q    (sw_sync)
   );

   // The filter bank sits between the synchronised pins and the input
   // register, so every reader sees the same filtered value.
   iro_filter #(
      .FILT_CYCLES (FILT_CYCLES)
   ) u_filter (
      .clk  (clk),
      .nrst (nrst),
      .f    (fif.flt)
   );

   // The filter bank sees the synchronised pins.
   assign fif.raw = iso_sync;
   // A channel filters when software enables the group or its switch
   // bit is set; the two controls are independent.
   assign fif.en  = {8{st_q.filt_en}} | sw_sync;

   // Address checks: inside the sixteen slots and word aligned.
   assign addr_ok = (paddr < `IRO_BLOCK_BYTES)
                    && (paddr[1:0] == 2'b00);
   // A setup cycle has psel high and penable low.
   assign setup   = psel && !penable;
   // The access ends at the edge where pready is seen high.
   assign done    = psel && penable && st_q.pready;
   // Only a completed, error-free write to byte lane zero takes effect.
   assign wr      = done && pwrite && !st_q.pslverr && pstrb[0];
   // Register data sit in the low byte.
   assign wbyte   = pwdata[7:0];

   // Edges of the filtered inputs; either direction counts, and for a
   // filtered AC input the loss of signal shows as a falling edge.
   assign edges = fif.lvl ^ st_q.prev;

   // Writing any value to the clear slot drops every pending change.
   assign clr = (wr && (paddr == `IRO_OFF_IRQ_CLR))
                ? 8'hff : 8'h00;

   // Read multiplexer; unused slots read as zero.
   always_comb begin
      rd_val = 32'h0000_0000;
      case (paddr)
         // Relay latches read back as written.
         `IRO_OFF_RELAY: begin
            rd_val[7:0] = st_q.relay;
         end
         // Filtered input levels.
         `IRO_OFF_INPUT: begin
            rd_val[7:0] = fif.lvl;
         end
         // Group filter enable as software left it.
         `IRO_OFF_FILT: begin
            rd_val[`IRO_FILT_EN_BIT] = st_q.filt_en;
         end
         // Current switch settings.
         `IRO_OFF_SWITCH: begin
            rd_val[7:0] = sw_sync;
         end
         // Interrupt enable.
         `IRO_OFF_IRQ_CTRL: begin
            rd_val[`IRO_IRQ_EN_BIT] = st_q.irq_en;
         end
         // Pending flag and the channels that changed.
         `IRO_OFF_IRQ_STAT: begin
            rd_val[`IRO_IRQ_PEND_BIT] = |st_q.chg;
            rd_val[`IRO_IRQ_CHG_LSB +: 8] = st_q.chg;
         end
         // Identifier; the only slot that differs between versions.
         `IRO_OFF_DEV_ID: begin
            rd_val[7:0] = DEV_ID;
         end
         // Every other slot reads as zero.
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // Next state of the register block.
   always_comb begin
      st_d = st_q;

      // The bus slave answers every access after one access cycle.
      case (st_q.bus)
         // Waiting for a setup cycle.
         IRO_BUS_IDLE: begin
            if (setup) begin
               st_d.bus     = IRO_BUS_ACCESS;
               st_d.pready  = 1'b1;
               st_d.pslverr = !addr_ok;
               st_d.prdata  = (addr_ok && !pwrite) ? rd_val
                                                   : 32'h0000_0000;
            end
         end
         // Access phase with pready already high.
         IRO_BUS_ACCESS: begin
            if (done) begin
               st_d.pready  = 1'b0;
               st_d.pslverr = 1'b0;
               st_d.prdata  = 32'h0000_0000;
               st_d.bus     = IRO_BUS_IDLE;
            end else if (!psel) begin
               // The master abandoned the transfer.
               st_d.pready  = 1'b0;
               st_d.pslverr = 1'b0;
               st_d.prdata  = 32'h0000_0000;
               st_d.bus     = IRO_BUS_IDLE;
            end
         end
         // An unknown phase returns to idle.
         default: begin
            st_d.bus    = IRO_BUS_IDLE;
            st_d.pready = 1'b0;
         end
      endcase

      // A relay write latches all eight bits until the next write.
      if (wr && (paddr == `IRO_OFF_RELAY)) begin
         st_d.relay = wbyte;
      end

      // Setting the group filter enable filters all channels at once; clearing it leaves channels with a switch bit set filtered.
      if (wr && (paddr == `IRO_OFF_FILT)) begin
         st_d.filt_en = wbyte[`IRO_FILT_EN_BIT];
      end

      // Software enables or disables the interrupt here.
      if (wr && (paddr == `IRO_OFF_IRQ_CTRL)) begin
         st_d.irq_en = wbyte[`IRO_IRQ_EN_BIT];
      end

      // Track the filtered levels for the edge detector.
      st_d.prev = fif.lvl;

      // Changes latch only while the interrupt is enabled, so enabling
      // it does not fire on history. A change arriving in the cycle of a
      // clear survives it.
      st_d.chg = (st_q.chg & ~clr)
                 | (st_q.irq_en ? edges : 8'h00);

      // The host line is low only while enabled and a change pends.
      st_d.int_n = !(st_d.irq_en && (|st_d.chg));
   end

   // Reset leaves relays off, filters and interrupt disabled and the
   // bus idle.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_q.bus     <= IRO_BUS_IDLE;
         st_q.relay   <= `IRO_RELAY_RST;
         st_q.filt_en <= `IRO_FILT_EN_RST;
         st_q.irq_en  <= `IRO_IRQ_EN_RST;
         st_q.prev    <= 8'h00;
         st_q.chg     <= `IRO_CHG_RST;
         st_q.prdata  <= 32'h0000_0000;
         st_q.pready  <= 1'b0;
         st_q.pslverr <= 1'b0;
         st_q.int_n   <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Every output comes straight from the state register.
   assign prdata   = st_q.prdata;
   assign pready   = st_q.pready;
   assign pslverr  = st_q.pslverr;
   assign relay_on = st_q.relay;
   assign int_a_n  = st_q.int_n;

endmodule : iro_top

/* dv/iro_assertions.sv */
// Concurrent checks on the ports of the isolated input and relay block.
`timescale 1ns/1ps
`include "iro_defines.svh"
module iro_chk import iro_pkg::*; #(
   parameter iro_cnt_t  FILT_CYCLES = iro_cnt_t'(`IRO_FILT_CYCLES),
   parameter iro_chan_t DEV_ID      = 8'h5a
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire iro_chan_t   iso_in,
   input wire iro_chan_t   filt_sw,
   input wire iro_chan_t   relay_on,
   input wire logic        int_a_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic wr_ok;  // A write that lands at this edge.
   logic rd_ok;  // A read whose data is taken at this edge.
   logic bad;    // Address outside the block or off word alignment.
   assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
   assign rd_ok = psel && penable && pready && !pwrite;
   assign bad   = paddr >= `IRO_BLOCK_BYTES || paddr[1:0] != 2'h0;
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   range_err_a: assert property (pready && bad |-> pslverr)
      else $error("bad address not refused");
   range_ok_a: assert property (pready && !bad |-> !pslverr)
      else $error("good address refused");
   idle_data_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   relay_write_a: assert property (wr_ok && paddr == `IRO_OFF_RELAY
      |=> relay_on == $past(pwdata[7:0])) else $error("relay not written");
   relay_hold_a: assert property (!(wr_ok && paddr == `IRO_OFF_RELAY)
      |=> $stable(relay_on)) else $error("relay changed unasked");
   relay_read_a: assert property (rd_ok && paddr == `IRO_OFF_RELAY
      |-> prdata == {24'h0, relay_on}) else $error("relay readback wrong");
   id_read_a: assert property (rd_ok && paddr == `IRO_OFF_DEV_ID
      |-> prdata == {24'h0, DEV_ID}) else $error("identifier wrong");
   irq_off_a: assert property (wr_ok && paddr == `IRO_OFF_IRQ_CTRL
      && !pwdata[0] |=> int_a_n) else $error("interrupt while disabled");
endmodule : iro_chk
bind iro_top iro_chk #(.FILT_CYCLES(FILT_CYCLES), .DEV_ID(DEV_ID)) u_chk (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .iso_in(iso_in),
   .filt_sw(filt_sw), .relay_on(relay_on), .int_a_n(int_a_n));

/* dv/iro_host.sv */
// Host software model: an APB master issuing register cycles.
`timescale 1ns/1ps
module iro_host (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // The bus lies idle until the first transfer.
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      pstrb   = 4'h0;
   end
   // Setup, then access held until pready is seen at an edge.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;  // Released lines do not keep the old value.
      pwdata  <= ~d;
   endtask : xfer
endmodule : iro_host

/* dv/tb_isolated_input_relay_output.sv */
// Self-checking bench for the isolated input and relay output block.
`timescale 1ns/1ps
`include "iro_defines.svh"
module tb_isolated_input_relay_output;
   import iro_pkg::*;
   localparam iro_cnt_t  FILT = 21'h10;
   localparam iro_chan_t ID   = 8'h3c;  // Arbitrary identifier.
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, int_a_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r, d;
   logic [3:0]  pstrb;
   logic        e;
   iro_chan_t   iso_in = 8'h00;
   iro_chan_t   filt_sw = 8'h00;
   iro_chan_t   relay_on, v, x, m_relay;
   int          n_errors = 0;
   int          checks = 0;
   int          cyc = 0;
   logic [7:0]  bad [3] = '{8'h40, 8'h02, 8'hfc};
   always #2 clk = ~clk;
   iro_top #(.FILT_CYCLES(FILT), .DEV_ID(ID)) u_dut (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .iso_in(iso_in), .filt_sw(filt_sw), .relay_on(relay_on),
      .int_a_n(int_a_n));
   iro_host u_host (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   // Prints the verdict and ends the run.
   task automatic stop_test();
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // Compares one value and reports a mismatch.
   task automatic chk(input string n, input logic [31:0] x, y);
      // Let the edge that launched the output settle before looking.
      #1;
      checks++;
      if (y !== x) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, x, y);
      end
   endtask : chk
   // One bus transfer, started one edge after the last.
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] dd, input logic [3:0] s);
      @(posedge clk);
      u_host.xfer(w, a, dd, s, r, e);
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [31:0] dd);
      acc(1'b1, a, dd, 4'hf);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0, 4'hf);
      chk("prdata", x, r);
      chk("pslverr", 32'h0, e);
   endtask : rd
   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      d = $urandom(32'hb2dd);
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rd(`IRO_OFF_RELAY, 32'h0);
      rd(`IRO_OFF_FILT, 32'h0);
      rd(`IRO_OFF_IRQ_CTRL, 32'h0);
      rd(`IRO_OFF_DEV_ID, ID);
      chk("int_a_n", 32'h1, int_a_n);
      m_relay = 8'h00;
      // Random relay writes; a clear strobe leaves the latch alone.
      repeat (6) begin
         d = $urandom;
         acc(1'b1, `IRO_OFF_RELAY, d, {3'h7, d[8]});
         if (d[8]) m_relay = d[7:0];
         rd(`IRO_OFF_RELAY, m_relay);
         chk("relay_on", m_relay, relay_on);
      end
      // Outside the block and misaligned: refused, nothing written.
      for (int i = 0; i < 3; i++) begin
         acc(1'b1, bad[i], ~d, 4'hf);
         chk("pslverr", 32'h1, e);
      end
      rd(`IRO_OFF_RELAY, m_relay);
      rd(8'h20, 32'h0);
      v = 8'($urandom);
      iso_in <= v;
      repeat (4) @(posedge clk);
      rd(`IRO_OFF_INPUT, v);
      wr(`IRO_OFF_FILT, 32'h1);
      rd(`IRO_OFF_FILT, 32'h1);
      // A glitch shorter than the filter is held off.
      x = ~v;
      iso_in <= x;
      repeat (FILT - 4) @(posedge clk);
      iso_in <= v;
      repeat (FILT + 6) @(posedge clk);
      rd(`IRO_OFF_INPUT, v);
      iso_in <= x;
      repeat (FILT + 6) @(posedge clk);
      rd(`IRO_OFF_INPUT, x);
      wr(`IRO_OFF_FILT, 32'h0);
      rd(`IRO_OFF_FILT, 32'h0);
      // Switches filter the low nibble only.
      filt_sw <= 8'h0f;
      repeat (4) @(posedge clk);
      rd(`IRO_OFF_SWITCH, 32'h0f);
      v = 8'($urandom);
      iso_in <= v;
      repeat (4) @(posedge clk);
      rd(`IRO_OFF_INPUT, {v[7:4], x[3:0]});
      repeat (FILT + 6) @(posedge clk);
      rd(`IRO_OFF_INPUT, v);
      // Changes on unfiltered channel 7 in both directions.
      wr(`IRO_OFF_IRQ_CTRL, 32'h1);
      rd(`IRO_OFF_IRQ_STAT, 32'h0);
      repeat (2) begin
         v = v ^ 8'h80;
         iso_in <= v;
         repeat (6) @(posedge clk);
         chk("int_a_n", 32'h0, int_a_n);
         rd(`IRO_OFF_IRQ_STAT, 32'h8001);
         wr(`IRO_OFF_IRQ_CLR, 32'h0);
         chk("int_a_n", 32'h1, int_a_n);
      end
      v = v ^ 8'h80;
      iso_in <= v;
      repeat (6) @(posedge clk);
      wr(`IRO_OFF_IRQ_CTRL, 32'h0);
      chk("int_a_n", 32'h1, int_a_n);
      rd(`IRO_OFF_IRQ_STAT, 32'h8001);
      wr(`IRO_OFF_IRQ_CLR, 32'h0);
      v = v ^ 8'h80;
      iso_in <= v;
      repeat (6) @(posedge clk);
      rd(`IRO_OFF_IRQ_STAT, 32'h0);
      // AC on filtered channel 0 reads steady; its loss is a change.
      wr(`IRO_OFF_IRQ_CTRL, 32'h1);
      repeat (10) begin
         iso_in <= v ^ 8'h01;
         @(posedge clk);
         iso_in <= v;
         repeat (2) @(posedge clk);
      end
      chk("int_a_n", 32'h1, int_a_n);
      iso_in <= v ^ 8'h01;
      repeat (FILT + 8) @(posedge clk);
      chk("int_a_n", 32'h0, int_a_n);
      rd(`IRO_OFF_IRQ_STAT, 32'h0101);
      // A reset in mid-run clears relays, filters and the interrupt.
      wr(`IRO_OFF_RELAY, 32'ha5);
      wr(`IRO_OFF_FILT, 32'h1);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk("relay_on", 32'h0, relay_on);
      chk("int_a_n", 32'h1, int_a_n);
      rd(`IRO_OFF_FILT, 32'h0);
      rd(`IRO_OFF_IRQ_CTRL, 32'h0);
      stop_test();
   end
endmodule : tb_isolated_input_relay_output
